// ---- core/uart_cfg_pkg.sv ----
// Purpose: Shared constants, states and parity helper of the serial port
// Assumes: Eight-bit register port, 16x oversampled baud tick
// Notes: Offsets are register indices on the local register port
package uart_cfg_pkg;
	// Register indices
	localparam logic [2:0] OFS_BAUD_HIGH = 3'h0;
	localparam logic [2:0] OFS_BAUD_LOW = 3'h1;
	localparam logic [2:0] OFS_FRAME_CTRL = 3'h2;
	localparam logic [2:0] OFS_PORT_CTRL = 3'h3;
	localparam logic [2:0] OFS_STATUS = 3'h4;
	localparam logic [2:0] OFS_DATA = 3'h5;
	localparam logic [2:0] OFS_EVENT = 3'h6;
	// Baud high fields
	localparam int BDH_BRK_IE = 7;
	localparam int BDH_EDGE_IE = 6;
	// Frame control fields
	localparam int C1_LOOP = 7;
	localparam int C1_FREEZE = 6;
	localparam int C1_RECEIVER_SOURCE_SELECT = 5;
	localparam int C1_NINE = 4;
	localparam int C1_WAKE = 3;
	localparam int C1_ILT = 2;
	localparam int C1_PE = 1;
	localparam int C1_PT = 0;
	// Port control fields
	localparam int C2_TX_BIT8 = 6;
	localparam int C2_DIR = 5;
	localparam int C2_BRK_LONG = 4;
	localparam int C2_TX_ON = 3;
	localparam int C2_RX_ON = 2;
	localparam int C2_STANDBY = 1;
	localparam int C2_SEND_BRK = 0;
	// Reset values
	localparam logic [7:0] BDH_RST = 8'h00;
	localparam logic [7:0] BDL_RST = 8'h04;
	localparam logic [7:0] C1_RST = 8'h00;
	localparam logic [7:0] C2_RST = 8'h00;
	// Cycle and bit counts
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] SUB_LAST = 4'hF;
	localparam logic [3:0] SAMPLE_AT = 4'h7;
	localparam logic [7:0] BRK_DET_TICKS = 8'(11 * OVERSAMPLE);
	localparam logic [3:0] BRK_TX_SHORT = 4'hA;
	localparam logic [3:0] BRK_TX_LONG = 4'hD;
	localparam logic [3:0] IDLE_BITS_8 = 4'hA;
	localparam logic [3:0] IDLE_BITS_9 = 4'hB;
	// States
	typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_START = 2'b01, TX_DATA = 2'b10,
		TX_STOP = 2'b11} tx_state_t;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10,
		RX_STOP = 2'b11} rx_state_t;
	// Parity bit that makes the whole character even, or odd when odd is set
	function automatic logic parity_bit(input logic [8:0] ch, input logic nine,
		input logic odd);
		parity_bit = (nine ? ^ch[7:0] : ^ch[6:0]) ^ odd;
	endfunction : parity_bit
endpackage : uart_cfg_pkg

// ---- core/uart_baud_gen.sv ----
// Purpose: Baud tick divider, one pulse every divisor clocks (16 per bit)
// Assumes: Divisor is stable while running
// Notes: Counter held at zero when stopped
`timescale 1ns/1ps
module uart_baud_gen import uart_cfg_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Control
	input wire logic run,
	input wire logic [12:0] divisor,
	// Tick
	output logic tick16
);
	typedef struct packed {
		logic [12:0] cnt;
		logic tick;
	} gen_regs_t;
	gen_regs_t gen_ff;
	gen_regs_t nxt_gen;

	always_comb begin
		nxt_gen = gen_ff;
		nxt_gen.tick = 1'b0;
		if (!run || divisor == 13'h0000) begin
			nxt_gen.cnt = 13'h0000;
		end else if (gen_ff.cnt >= divisor - 13'h0001) begin
			nxt_gen.cnt = 13'h0000;
			nxt_gen.tick = 1'b1;
		end else begin
			nxt_gen.cnt = gen_ff.cnt + 13'h0001;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			gen_ff <= '0;
		end else begin
			gen_ff <= nxt_gen;
		end
	end

	assign tick16 = gen_ff.tick;
endmodule : uart_baud_gen

// ---- core/uart_tx_shift.sv ----
// Purpose: Transmit shifter for data and break characters
// Assumes: Start accepted only while idle
// Notes: Line idles high
`timescale 1ns/1ps
module uart_tx_shift import uart_cfg_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Timing
	input wire logic tick16,
	// Request
	input wire logic start,
	input wire logic is_break,
	input wire logic [8:0] data,
	// Frame options
	input wire logic nine_bit,
	input wire logic parity_en,
	input wire logic parity_odd,
	input wire logic break_long,
	// Line
	output logic busy,
	output logic line
);
	typedef struct packed {
		tx_state_t st;
		logic [3:0] sub;
		logic [3:0] bitn;
		logic [3:0] last;
		logic [8:0] sh;
		logic line;
	} tx_regs_t;
	tx_regs_t tx_ff;
	tx_regs_t nxt_tx;

	always_comb begin
		nxt_tx = tx_ff;
		unique case (tx_ff.st)
			TX_IDLE: begin
				nxt_tx.line = 1'b1;
				if (start) begin
					nxt_tx.st = TX_START;
					nxt_tx.sub = 4'h0;
					nxt_tx.bitn = 4'h0;
					nxt_tx.line = 1'b0;
					// RL17 Short or long break
					if (is_break) begin
						nxt_tx.sh = 9'h000;
						nxt_tx.last = (break_long ? BRK_TX_LONG : BRK_TX_SHORT)
							+ {3'b000, nine_bit} - 4'h2;
					end else begin
						nxt_tx.sh = nine_bit ? data : {1'b0, data[7:0]};
						nxt_tx.last = nine_bit ? 4'h8 : 4'h7;
						// RL15 Parity generation
						if (parity_en && nine_bit) begin
							nxt_tx.sh[8] = parity_bit(data, 1'b1, parity_odd);
						end else if (parity_en) begin
							nxt_tx.sh[7] = parity_bit(data, 1'b0, parity_odd);
						end
					end
				end
			end
			TX_START: begin
				if (tick16) begin
					nxt_tx.sub = tx_ff.sub + 4'h1;
					if (tx_ff.sub == SUB_LAST) begin
						nxt_tx.st = TX_DATA;
						nxt_tx.line = tx_ff.sh[0];
					end
				end
			end
			TX_DATA: begin
				if (tick16) begin
					nxt_tx.sub = tx_ff.sub + 4'h1;
					if (tx_ff.sub == SUB_LAST && tx_ff.bitn == tx_ff.last) begin
						nxt_tx.st = TX_STOP;
						nxt_tx.line = 1'b1;
					end else if (tx_ff.sub == SUB_LAST) begin
						nxt_tx.bitn = tx_ff.bitn + 4'h1;
						nxt_tx.line = tx_ff.sh[1];
						nxt_tx.sh = {1'b0, tx_ff.sh[8:1]};
					end
				end
			end
			TX_STOP: begin
				if (tick16) begin
					nxt_tx.sub = tx_ff.sub + 4'h1;
					if (tx_ff.sub == SUB_LAST) begin
						nxt_tx.st = TX_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			tx_ff <= '0;
			tx_ff.line <= 1'b1;
		end else begin
			tx_ff <= nxt_tx;
		end
	end

	assign busy = (tx_ff.st != TX_IDLE);
	assign line = tx_ff.line;
endmodule : uart_tx_shift

// ---- core/uart_baud_frame_config.sv ----
// Purpose: Serial port with baud divisor, framing, routing and flag logic
// Assumes: Register port and pins synchronous to clock
// Notes: Baud tick is 16x bit rate; register read data one cycle late
`timescale 1ns/1ps
// Contract
// RL1 - High divisor held until low written
// RL2 - Low divisor nonzero; generator off until enabled
// RL3 - Zero divisor stops baud generator
// RL4 - Baud equals clock over sixteen times divisor
// RL5 - Divisor split five high, eight low
// RL6 - Bit seven enables break interrupt
// RL7 - Bit six enables receive edge interrupt
// RL8 - Loopback feeds transmitter into receiver
// RL9 - Source bit matters only in loopback
// RL10 - Loopback plus source gives single wire
// RL11 - Freeze bit stops clocks in wait
// RL12 - Frame bit selects eight or nine data
// RL13 - Wake method: idle line or address mark
// RL14 - Idle count origin after start or stop
// RL15 - Parity generated and checked on MSB
// RL16 - Even parity at zero, odd at one
// RL17 - Thirteen bit break send, eleven detect
// RL18 - Double buffered, separate enables
// RL19 - Transmitter drives pin only when enabled; code also drives it while a character is still shifting
// RL20 - Direction bit steers single wire pin
// RL21 - Loopback releases receive pin
// RL22 - Line idles high, start low, stop high
// RL23 - Software writes high before low
module uart_baud_frame_config import uart_cfg_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Processor state
	input wire logic wait_mode,
	// Serial pins
	input wire logic txd_in,
	output logic txd_out,
	output logic txd_oe,
	input wire logic rxd_in,
	output logic rxd_released,
	// Interrupt request
	output logic irq_request
);
	typedef struct packed {
		logic [7:0] bdh_buf;
		logic [4:0] div_hi;
		logic [7:0] bdl;
		logic [7:0] c1;
		logic [7:0] c2;
		logic gen_on;
		logic [8:0] tx_buf;
		logic tx_full;
		logic [8:0] rx_data;
		logic rx_full;
		logic overrun;
		logic frm_err;
		logic par_err;
		logic idle_flag;
		logic brk_flag;
		logic edge_flag;
		logic rx_prev;
		rx_state_t rx_st;
		logic [3:0] rx_sub;
		logic [3:0] rx_bitn;
		logic [8:0] rx_sh;
		logic [7:0] low_ticks;
		logic [3:0] idle_run;
		logic idle_arm;
		logic [7:0] rdata;
	} port_regs_t;
	port_regs_t port_ff;
	port_regs_t nxt_port;

	logic tick16;
	logic tx_busy;
	logic tx_line;
	logic tx_go;
	logic gen_run;
	logic loop_on;
	logic single_wire;
	logic rx_line;
	logic nine;
	logic [12:0] divisor;

	function automatic logic wr_hit(input logic [2:0] ofs);
		wr_hit = reg_wr && (reg_addr == ofs);
	endfunction : wr_hit

	// RL5 Divisor assembly
	assign divisor = {port_ff.div_hi, port_ff.bdl};
	assign nine = port_ff.c1[C1_NINE];
	// RL2 Generator gated
	// RL11 Wait freeze
	assign gen_run = port_ff.gen_on && !(wait_mode && port_ff.c1[C1_FREEZE]);
	// RL8 Loopback routing
	// RL9 Source select
	// RL10 Single wire input
	assign loop_on = port_ff.c1[C1_LOOP];
	assign single_wire = loop_on && port_ff.c1[C1_RECEIVER_SOURCE_SELECT];
	assign rx_line = !loop_on ? rxd_in : (single_wire ? txd_in : tx_line);
	// RL18 Buffer to shifter
	// RL11 No start while frozen
	assign tx_go = port_ff.c2[C2_TX_ON] && !tx_busy && gen_run
		&& (port_ff.c2[C2_SEND_BRK] || port_ff.tx_full);

	// RL3 Zero divisor stop
	// RL4 Sixteen ticks per bit
	uart_baud_gen uart_baud_gen_i (
		.clock(clock),
		.srst(srst),
		.run(gen_run),
		.divisor(divisor),
		.tick16(tick16)
	);

	uart_tx_shift uart_tx_shift_i (
		.clock(clock),
		.srst(srst),
		.tick16(tick16),
		.start(tx_go),
		.is_break(port_ff.c2[C2_SEND_BRK]),
		.data(port_ff.tx_buf),
		.nine_bit(nine),
		.parity_en(port_ff.c1[C1_PE]),
		.parity_odd(port_ff.c1[C1_PT]),
		.break_long(port_ff.c2[C2_BRK_LONG]),
		.busy(tx_busy),
		.line(tx_line)
	);

	always_comb begin
		logic [8:0] sh;
		logic [8:0] ch;
		logic msb;
		logic perr;
		logic [3:0] thr;
		sh = {rx_line, port_ff.rx_sh[8:1]};
		ch = nine ? sh : {1'b0, sh[8:1]};
		msb = nine ? ch[8] : ch[7];
		// RL15 Parity check
		// RL16 Parity sense
		perr = port_ff.c1[C1_PE] && (parity_bit(ch, nine, port_ff.c1[C1_PT]) != msb);
		thr = nine ? IDLE_BITS_9 : IDLE_BITS_8;
		nxt_port = port_ff;
		nxt_port.rx_prev = rx_line;

		// Clears by software and by tx_go come first, so later hardware sets and data writes win
		if (tx_go && !port_ff.c2[C2_SEND_BRK]) begin
			nxt_port.tx_full = 1'b0;
		end
		if (reg_rd && reg_addr == OFS_DATA) begin
			nxt_port.rx_full = 1'b0;
		end
		if (wr_hit(OFS_STATUS)) begin
			nxt_port.idle_flag = port_ff.idle_flag & ~reg_wdata[4];
			nxt_port.overrun = port_ff.overrun & ~reg_wdata[3];
			nxt_port.frm_err = port_ff.frm_err & ~reg_wdata[1];
			nxt_port.par_err = port_ff.par_err & ~reg_wdata[0];
		end
		if (wr_hit(OFS_EVENT)) begin
			nxt_port.brk_flag = port_ff.brk_flag & ~reg_wdata[7];
			nxt_port.edge_flag = port_ff.edge_flag & ~reg_wdata[6];
		end

		// Register writes
		// RL1 Buffered high half
		if (wr_hit(OFS_BAUD_HIGH)) begin
			nxt_port.bdh_buf = reg_wdata;
		end
		if (wr_hit(OFS_BAUD_LOW)) begin
			nxt_port.bdl = reg_wdata;
			nxt_port.div_hi = port_ff.bdh_buf[4:0];
		end
		if (wr_hit(OFS_FRAME_CTRL)) begin
			nxt_port.c1 = reg_wdata;
		end
		// RL2 First enable starts generator
		if (wr_hit(OFS_PORT_CTRL)) begin
			nxt_port.c2 = reg_wdata;
			if (reg_wdata[C2_TX_ON] || reg_wdata[C2_RX_ON]) begin
				nxt_port.gen_on = 1'b1;
			end
		end
		if (wr_hit(OFS_DATA)) begin
			nxt_port.tx_buf = {port_ff.c2[C2_TX_BIT8], reg_wdata};
			nxt_port.tx_full = 1'b1;
		end

		// Receive edge flag
		if (port_ff.c2[C2_RX_ON] && port_ff.rx_prev && !rx_line) begin
			nxt_port.edge_flag = 1'b1;
		end

		// Receiver
		if (!port_ff.c2[C2_RX_ON]) begin
			nxt_port.rx_st = RX_IDLE;
			nxt_port.low_ticks = 8'h00;
		end else if (tick16) begin
			// RL17 Break detect
			if (rx_line) begin
				nxt_port.low_ticks = 8'h00;
			end else if (port_ff.low_ticks != 8'hFF) begin
				nxt_port.low_ticks = port_ff.low_ticks + 8'h01;
				if (port_ff.low_ticks == BRK_DET_TICKS - 8'h01) begin
					nxt_port.brk_flag = 1'b1;
				end
			end
			nxt_port.rx_sub = port_ff.rx_sub + 4'h1;
			unique case (port_ff.rx_st)
				RX_IDLE: begin
					// RL22 Start bit is low
					if (!rx_line) begin
						nxt_port.rx_st = RX_START;
						nxt_port.rx_sub = 4'h0;
					end else if (port_ff.rx_sub == SUB_LAST
						&& port_ff.idle_run != 4'hF) begin
						nxt_port.idle_run = port_ff.idle_run + 4'h1;
					end
				end
				RX_START: begin
					if (port_ff.rx_sub == SAMPLE_AT) begin
						nxt_port.rx_st = rx_line ? RX_IDLE : RX_DATA;
						nxt_port.rx_bitn = 4'h0;
						// RL14 Count restarts
						nxt_port.idle_run = 4'h0;
					end
				end
				RX_DATA: begin
					if (port_ff.rx_sub == SAMPLE_AT) begin
						nxt_port.rx_sh = sh;
						// RL14 Origin after start
						if (!port_ff.c1[C1_ILT] && rx_line) begin
							nxt_port.idle_run = port_ff.idle_run + 4'h1;
						end else begin
							nxt_port.idle_run = 4'h0;
						end
						// RL12 Eight or nine bits
						if (port_ff.rx_bitn == (nine ? 4'h8 : 4'h7)) begin
							nxt_port.rx_st = RX_STOP;
						end else begin
							nxt_port.rx_bitn = port_ff.rx_bitn + 4'h1;
						end
					end
				end
				RX_STOP: begin
					if (port_ff.rx_sub == SAMPLE_AT) begin
						nxt_port.rx_st = RX_IDLE;
						nxt_port.idle_arm = 1'b1;
						ch = nine ? port_ff.rx_sh : {1'b0, port_ff.rx_sh[8:1]};
						msb = nine ? ch[8] : ch[7];
						perr = port_ff.c1[C1_PE]
							&& (parity_bit(ch, nine, port_ff.c1[C1_PT]) != msb);
						// RL14 Origin after stop
						if (!port_ff.c1[C1_ILT] && rx_line) begin
							nxt_port.idle_run = port_ff.idle_run + 4'h1;
						end else begin
							nxt_port.idle_run = 4'h0;
						end
						// RL13 Address mark wake
						if (port_ff.c2[C2_STANDBY] && port_ff.c1[C1_WAKE] && msb) begin
							nxt_port.c2[C2_STANDBY] = 1'b0;
						end
						if (!port_ff.c2[C2_STANDBY]
							|| (port_ff.c1[C1_WAKE] && msb)) begin
							// RL18 Receive buffer
							if (port_ff.rx_full) begin
								nxt_port.overrun = 1'b1;
							end else begin
								nxt_port.rx_data = ch;
								nxt_port.rx_full = 1'b1;
								nxt_port.par_err = perr;
								nxt_port.frm_err = !rx_line;
							end
						end
					end
				end
			endcase
		end

		// RL13 Idle line wake
		if (port_ff.idle_arm && port_ff.idle_run >= thr) begin
			nxt_port.idle_arm = 1'b0;
			nxt_port.idle_flag = 1'b1;
			if (!port_ff.c1[C1_WAKE]) begin
				nxt_port.c2[C2_STANDBY] = 1'b0;
			end
		end

		// Register read data
		if (reg_rd) begin
			unique case (reg_addr)
				// Reserved bit five reads zero
				OFS_BAUD_HIGH: nxt_port.rdata = {port_ff.bdh_buf[7:6], 1'b0,
					port_ff.bdh_buf[4:0]};
				OFS_BAUD_LOW: nxt_port.rdata = port_ff.bdl;
				OFS_FRAME_CTRL: nxt_port.rdata = port_ff.c1;
				OFS_PORT_CTRL: nxt_port.rdata = port_ff.c2;
				OFS_STATUS: nxt_port.rdata = {!port_ff.tx_full, !tx_busy,
					port_ff.rx_full, port_ff.idle_flag, port_ff.overrun,
					port_ff.rx_data[8], port_ff.frm_err, port_ff.par_err};
				OFS_DATA: nxt_port.rdata = port_ff.rx_data[7:0];
				OFS_EVENT: nxt_port.rdata = {port_ff.brk_flag, port_ff.edge_flag,
					5'b00000, rx_line};
				default: nxt_port.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			port_ff <= '0;
			port_ff.bdh_buf <= BDH_RST;
			port_ff.bdl <= BDL_RST;
			port_ff.c1 <= C1_RST;
			port_ff.c2 <= C2_RST;
			port_ff.rx_prev <= 1'b1;
		end else begin
			port_ff <= nxt_port;
		end
	end

	assign reg_rdata = port_ff.rdata;
	assign txd_out = tx_line;
	// RL19 Pin owned by transmitter
	// RL20 Single wire direction
	assign txd_oe = (port_ff.c2[C2_TX_ON] || tx_busy)
		&& (!single_wire || port_ff.c2[C2_DIR]);
	// RL21 Receive pin released
	assign rxd_released = !(port_ff.c2[C2_RX_ON] && !loop_on);
	// RL6 Break interrupt enable
	// RL7 Edge interrupt enable
	assign irq_request = (port_ff.bdh_buf[BDH_BRK_IE] && port_ff.brk_flag)
		|| (port_ff.bdh_buf[BDH_EDGE_IE] && port_ff.edge_flag);
endmodule : uart_baud_frame_config

// ---- test/uart_baud_frame_config_assertions.sv ----
// Purpose: Port checks of the serial configuration block
// Assumes: Register indices from the package
// Notes: Helper copies follow the written control registers
`timescale 1ns/1ps
module uart_baud_frame_config_assertions import uart_cfg_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	// Pins and request
	input wire logic wait_mode,
	input wire logic txd_in,
	input wire logic txd_out,
	input wire logic txd_oe,
	input wire logic rxd_in,
	input wire logic rxd_released,
	input wire logic irq_request
);
	logic [7:0] high_ff, c1_ff, c2_ff;
	logic [12:0] div_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	// Written register copies
	always_ff @(posedge clock) begin
		if (srst) begin
			high_ff <= 8'h00;
			c1_ff <= 8'h00;
			c2_ff <= 8'h00;
			div_ff <= 13'h0004;
		end else if (reg_wr) begin
			case (reg_addr)
				OFS_BAUD_HIGH: high_ff <= reg_wdata;
				OFS_BAUD_LOW: div_ff <= {high_ff[4:0], reg_wdata};
				OFS_FRAME_CTRL: c1_ff <= reg_wdata;
				OFS_PORT_CTRL: c2_ff <= reg_wdata;
				default: ;
			endcase
		end
	end
	reset_idle_a: assert property ($fell(srst) |-> reg_rdata == 8'h00 && txd_out && !txd_oe
		&& rxd_released && !irq_request) else $error("outputs wrong after reset");
	unmapped_zero_a: assert property (reg_rd && reg_addr == 3'h7 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	high_readback_a: assert property (reg_rd && reg_addr == OFS_BAUD_HIGH |=>
		reg_rdata == {high_ff[7:6], 1'b0, high_ff[4:0]})
		else $error("high divisor readback wrong");
	frame_readback_a: assert property (reg_rd && reg_addr == OFS_FRAME_CTRL |=>
		reg_rdata == c1_ff) else $error("frame control readback wrong");
	loop_release_a: assert property (c1_ff[C1_LOOP] && $past(c1_ff[C1_LOOP])
		|-> rxd_released) else $error("receive pin held in loopback");
	tx_gate_a: assert property ($rose(txd_oe) |-> c2_ff[C2_TX_ON])
		else $error("pin driven without transmitter");
	irq_gate_a: assert property (irq_request |-> high_ff[BDH_BRK_IE] || high_ff[BDH_EDGE_IE])
		else $error("request without enable");
	edge_irq_a: assert property ($fell(rxd_in) && high_ff[BDH_EDGE_IE] && c2_ff[C2_RX_ON]
		&& !c1_ff[C1_LOOP] |-> ##[1:4] irq_request) else $error("edge request missing");
	low_bit_a: assert property ($fell(txd_out) |-> (!txd_out) [*8] ##1 (!txd_out) [*8])
		else $error("low bit shorter than sixteen clocks");
	zero_halt_a: assert property (div_ff == 13'h0000 && $past(div_ff) == 13'h0000
		|-> !$rose(txd_out)) else $error("line moved with zero divisor");
	wait_freeze_a: assert property (wait_mode && c1_ff[C1_FREEZE]
		&& $past(wait_mode) && $past(c1_ff[C1_FREEZE]) |=> $stable(txd_out))
		else $error("line moved while frozen");
	cover property ($fell(txd_out));
	cover property (wait_mode && c1_ff[C1_FREEZE]);
	cover property (irq_request);
	cover property (c1_ff[C1_LOOP] && c1_ff[C1_RECEIVER_SOURCE_SELECT] && txd_oe);
endmodule : uart_baud_frame_config_assertions
bind uart_baud_frame_config uart_baud_frame_config_assertions uart_baud_frame_config_assertions_i (
	.clock, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .wait_mode,
	.txd_in, .txd_out, .txd_oe, .rxd_in, .rxd_released, .irq_request);

// ---- test/serial_peer.sv ----
// Purpose: Remote serial transceiver model
// Assumes: Bit period given in clocks
// Notes: Line idles high, frames least significant bit first
`timescale 1ns/1ps
module serial_peer (
	// Clock
	input wire logic clock,
	// Frame options
	input wire logic [15:0] bit_clks,
	input wire logic nine,
	// Line
	input wire logic line_in,
	output logic line_out,
	// Received character
	output logic got,
	output logic [8:0] got_data
);
	int n;
	initial begin
		line_out = 1'b1;
		got = 1'b0;
		got_data = 9'h000;
	end
	always begin
		@(negedge line_in);
		repeat (bit_clks / 2) @(posedge clock);
		got_data = 9'h000;
		for (n = 0; n < (nine ? 9 : 8); n++) begin
			repeat (bit_clks) @(posedge clock);
			got_data[n] = line_in;
		end
		repeat (bit_clks) @(posedge clock);
		got <= line_in;
		@(posedge clock);
		got <= 1'b0;
	end
	task automatic send_char(input logic [8:0] ch);
		int k;
		line_out <= 1'b0;
		repeat (bit_clks) @(posedge clock);
		for (k = 0; k < (nine ? 9 : 8); k++) begin
			line_out <= ch[k];
			repeat (bit_clks) @(posedge clock);
		end
		line_out <= 1'b1;
		repeat (bit_clks) @(posedge clock);
	endtask : send_char
endmodule : serial_peer

// ---- test/uart_baud_frame_config_tb.sv ----
// Purpose: Self-checking bench of the serial configuration block
// Assumes: Divisor 1 or 2 keeps frames short
// Notes: Reads and received frames compared from queues
`timescale 1ns/1ps
module uart_baud_frame_config_tb import uart_cfg_pkg::*; ;
	logic clock, srst, reg_wr, reg_rd, wait_mode, nine, b8, rd_d;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d, fc;
	logic txd_out, txd_oe, rxd_released, irq_request, peer_line, got;
	logic [8:0] got_data, ch;
	logic [15:0] bit_clks;
	wire logic txd_pin;
	logic [7:0] rd_q[$];
	logic [8:0] fr_q[$];
	int n_fail = 0;
	int tests_run = 0;
	int seed, j;
	assign txd_pin = txd_oe ? txd_out : peer_line;
	uart_baud_frame_config uart_baud_frame_config_i (.clock, .srst, .reg_addr, .reg_wr,
		.reg_rd, .reg_wdata, .reg_rdata, .wait_mode, .txd_in(txd_pin), .txd_out, .txd_oe,
		.rxd_in(peer_line), .rxd_released, .irq_request);
	serial_peer serial_peer_i (.clock, .bit_clks, .nine, .line_in(txd_pin),
		.line_out(peer_line), .got, .got_data);
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clock);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clock);
		reg_rd = 1'b0;
	endtask : rd
	task automatic tx_char(input logic [7:0] v, input logic [8:0] e);
		int k;
		fr_q.push_back(e);
		wr(OFS_DATA, v);
		for (k = 0; k < 2000 && fr_q.size() != 0; k++) @(negedge clock);
		repeat (bit_clks) @(negedge clock);
	endtask : tx_char
	task automatic finish_test();
		$display("Checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	// Result watcher
	always @(posedge clock) rd_d <= reg_rd;
	always @(negedge clock) begin
		if (rd_d) check("read data", {1'b0, reg_rdata}, {1'b0, rd_q.pop_front()});
		if (got) check("peer frame", got_data, fr_q.pop_front());
	end
	initial begin
		#100000;
		n_fail++;
		finish_test();
	end
	initial begin
		seed = 32'hf119_9a7f;
		srst = 1'b1;
		reg_addr = 3'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		wait_mode = 1'b0;
		nine = 1'b0;
		bit_clks = 16'h0010;
		repeat (4) @(negedge clock);
		srst = 1'b0;
		rd(OFS_BAUD_HIGH, 8'h00);
		rd(OFS_BAUD_LOW, 8'h04);
		rd(OFS_FRAME_CTRL, 8'h00);
		rd(3'h7, 8'h00);
		$display("Test reset values done");
		wr(OFS_BAUD_HIGH, 8'h00);
		wr(OFS_BAUD_LOW, 8'h01);
		for (j = 0; j < 8; j++) begin
			b8 = 1'($random(seed));
			d = 8'($random(seed));
			nine = j[2];
			wait_mode = j[0];
			fc = {3'b000, j[2], 2'b00, j[1], j[0]};
			wr(OFS_FRAME_CTRL, fc);
			wr(OFS_PORT_CTRL, {1'b0, b8, 6'b001100});
			rd(OFS_FRAME_CTRL, fc);
			ch = {b8 & j[2], d};
			if (j[1] && j[2]) ch[8] = ^ch[7:0] ^ j[0];
			if (j[1] && !j[2]) ch[7] = ^ch[6:0] ^ j[0];
			tx_char(d, ch);
		end
		wait_mode = 1'b0;
		nine = 1'b0;
		$display("Test framing and parity done");
		wr(OFS_FRAME_CTRL, 8'h00);
		wr(OFS_BAUD_HIGH, 8'h01);
		rd(OFS_BAUD_HIGH, 8'h01);
		tx_char(8'ha5, 9'h0a5);
		wr(OFS_BAUD_HIGH, 8'h00);
		wr(OFS_BAUD_LOW, 8'h02);
		bit_clks = 16'h0020;
		tx_char(8'h3c, 9'h03c);
		$display("Test divisor buffering done");
		bit_clks = 16'h0010;
		wr(OFS_BAUD_HIGH, 8'h40);
		wr(OFS_BAUD_LOW, 8'h01);
		d = 8'($random(seed));
		serial_peer_i.send_char({1'b0, d});
		rd(OFS_DATA, d);
		rd(OFS_EVENT, 8'h41);
		$display("Test receive done");
		wr(OFS_FRAME_CTRL, 8'h40);
		wait_mode = 1'b1;
		wr(OFS_DATA, 8'h5a);
		repeat (100) @(negedge clock);
		check("frozen line", {8'h00, txd_out}, 9'h001);
		check("tx pin driven", {8'h00, txd_oe}, 9'h001);
		check("rx pin owned", {8'h00, rxd_released}, 9'h000);
		check("edge request", {8'h00, irq_request}, 9'h001);
		fr_q.push_back(9'h05a);
		wait_mode = 1'b0;
		d = 8'($random(seed));
		tx_char(d, {1'b0, d});
		$display("Test wait freeze done");
		for (j = 0; j < 2; j++) begin
			wr(OFS_FRAME_CTRL, j ? 8'ha0 : 8'h80);
			wr(OFS_PORT_CTRL, j ? 8'h2c : 8'h0c);
			d = 8'($random(seed));
			tx_char(d, {1'b0, d});
			check("rx pin freed", {8'h00, rxd_released}, 9'h001);
			check("shared pin driven", {8'h00, txd_oe}, 9'h001);
			rd(OFS_DATA, d);
		end
		$display("Test loop modes done");
		wr(OFS_BAUD_HIGH, 8'h80);
		wr(OFS_BAUD_LOW, 8'h01);
		wr(OFS_FRAME_CTRL, 8'h80);
		wr(OFS_PORT_CTRL, 8'h1d);
		repeat (240) @(negedge clock);
		wr(OFS_PORT_CTRL, 8'h0c);
		repeat (240) @(negedge clock);
		rd(OFS_EVENT, 8'hc1);
		check("break request", {8'h00, irq_request}, 9'h001);
		$display("Test break done");
		wr(OFS_FRAME_CTRL, 8'h00);
		wr(OFS_PORT_CTRL, 8'h0c);
		wr(OFS_BAUD_HIGH, 8'h00);
		wr(OFS_BAUD_LOW, 8'h00);
		wr(OFS_DATA, 8'h00);
		repeat (400) @(negedge clock);
		check("stalled line", {8'h00, txd_out}, 9'h000);
		srst = 1'b1;
		repeat (4) @(negedge clock);
		srst = 1'b0;
		rd(OFS_BAUD_LOW, 8'h04);
		repeat (4) @(negedge clock);
		check("queues left", 9'(fr_q.size() + rd_q.size()), 9'h000);
		$display("Test zero divisor done");
		finish_test();
	end
endmodule : uart_baud_frame_config_tb
